// ### cog_clock_output_gating.sv
// Behaviour
// - standard mode: any indicator change of any loop drives irq_out_n low
// - each indicator has a mask bit; masked ones never raise the interrupt
// - interrupt goes inactive only after host clears or masks causing sticky flags
// - pps mode: loop D excluded from irq, its lock loss shown on pin
// - seven drivers, each differential or single ended on both pins
// - crosspoint picks any loop per driver, loaded at power-up
// - single ended complementary pin in phase unless inverted by setting
// - output 5 makes 1 Hz by cascading output 6 divider into output 5
// - global_out_en_n high disables all drivers, low enables them
// - each driver individually disabled by its own register bit
// - lock loss keeps clocks by default; option disables in standard mode
// - crystal loss disables all outputs by default; option keeps them
// - disabled driver holds register selected low or high level
// - synchronous disable waits for the clock's low phase, asynchronous stops at once
// - dividers reset at power-up, reset pin or hard-reset bit
// - pps mode applies programmed phase offset to loop D outputs
// - drivers and loops each power down by configuration
// - drive select accepts codes 1 to 3; avoid 1 at 1.8 V
// - sticky flags hold until cleared; live flags show present state
// - crystal-loss alarm asserts when oscillator reference becomes invalid
`timescale 1ns/10ps
`default_nettype none

module cog_clock_output_gating (
   // apb
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic      [31:0] prdata,
   output logic             pslverr,
   // loop clocks and status
   input  wire logic [2:0]  loop_clk,
   input  wire cog_pkg::cog_stat_t live,
   input  wire logic        osc_valid,
   input  wire logic        global_out_en_n,
   // pins
   output logic      [6:0]  clk_out_true,
   output logic      [6:0]  clk_out_comp,
   output logic      [13:0] single_ended_drive_sel,
   output logic             crystal_loss_alarm,
   output logic             irq_out_n,
   output logic             loop_d_unlock_pin_n,
   output logic             div_reset
);

   cog_pkg::cog_state_t st;
   cog_pkg::cog_state_t next_st;

   logic [11:0] live_vec;
   logic [11:0] irq_en;
   logic [6:0]  dis;
   logic [6:0]  src_clk;
   logic [15:0] cnt5;
   logic [15:0] cnt6;
   logic [15:0] next_cnt5;
   logic [15:0] next_cnt6;
   logic        tick5;
   logic        tick6;
   logic        clk5;
   logic        clk6;
   logic        wr;
   logic        rd;
   logic        hard_rst;
   logic [7:0]  dly;
   logic [7:0]  next_dly;

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [1:0] xp_sel(input logic [20:0] x, input int i);
      return x[3*i +: 2];
   endfunction

   function automatic logic pick(input logic [2:0] c, input logic [1:0] s);
      return (s < 2'h3) ? c[s] : 1'b0;
   endfunction

   // ----------------------------------------
   // bus decode
   // ----------------------------------------
   assign pready  = 1'b1;
   assign pslverr = 1'b0;
   assign wr      = psel & penable & pwrite;
   assign rd      = psel & ~pwrite;
   assign prdata  = st.prdata;

   // ----------------------------------------
   // status and crystal alarm
   // ----------------------------------------
   assign live_vec = {live.hold, live.oof, live.los, live.lock_loss};
   assign crystal_loss_alarm = ~osc_valid;
   assign hard_rst = st.ctrl[cog_pkg::CTRL_HRST];
   assign div_reset = hard_rst;

   always_comb begin
      irq_en = ~st.mask;
      if (st.ctrl[cog_pkg::CTRL_PPS]) begin
         for (int k = 0; k < cog_pkg::N_STAT; k++) begin
            irq_en[k*cog_pkg::N_LOOP + cog_pkg::LOOP_D] = 1'b0;
         end
      end
   end

   // ----------------------------------------
   // output dividers with cascade
   // ----------------------------------------
   // cascade divide
   assign tick6 = (cnt6 == 16'h0000);
   assign clk6  = (cnt6 < (st.div6 >> 1));
   assign tick5 = st.ctrl[cog_pkg::CTRL_CASCADE] ? tick6 : 1'b1;
   assign clk5  = (cnt5 < (st.div5 >> 1));

   always_comb begin
      next_cnt6 = (cnt6 == 16'h0000) ? st.div6 - 16'h0001 : cnt6 - 16'h0001;
      next_cnt5 = cnt5;
      if (tick5) begin
         next_cnt5 = (cnt5 == 16'h0000) ? st.div5 - 16'h0001
                                        : cnt5 - 16'h0001;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt5 <= 16'h0000;
         cnt6 <= 16'h0000;
         dly  <= 8'h00;
      end else if (hard_rst) begin
         cnt5 <= 16'h0000;
         cnt6 <= 16'h0000;
         dly  <= 8'h00;
      end else begin
         cnt5 <= next_cnt5;
         cnt6 <= next_cnt6;
         dly  <= next_dly;
      end
   end

   // ----------------------------------------
   // crosspoint and gating
   // ----------------------------------------
   logic d_shift;
   always_comb begin
      next_dly = {dly[6:0], loop_clk[cog_pkg::LOOP_D]};
      d_shift = (st.ctrl[cog_pkg::CTRL_PPS] && st.phase != 8'h00)
                ? dly[st.phase[2:0] - 3'h1] : loop_clk[cog_pkg::LOOP_D];
   end

   always_comb begin
      for (int i = 0; i < cog_pkg::N_OUT; i++) begin
         if (xp_sel(st.xp, i) == 2'h2) begin
            src_clk[i] = d_shift;
         end else begin
            src_clk[i] = pick(loop_clk, xp_sel(st.xp, i));
         end
         dis[i] = global_out_en_n                               // pin
                | st.out_dis[i]                                 // bit
                | st.pwr[i]                                     // power
                | pick(st.pwr[9:7], xp_sel(st.xp, i))           // loop
                | (~osc_valid & ~st.ctrl[cog_pkg::CTRL_XKEEP])  // xtal
                | (st.ctrl[cog_pkg::CTRL_LOLDIS]
                   & ~st.ctrl[cog_pkg::CTRL_PPS]
                   & pick(live.lock_loss, xp_sel(st.xp, i)));
      end
      src_clk[5] = st.ctrl[cog_pkg::CTRL_CASCADE] ? clk5 : src_clk[5];
      src_clk[6] = st.ctrl[cog_pkg::CTRL_CASCADE] ? clk6 : src_clk[6];
   end

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      next_st = st;
      next_st.prev   = live_vec;
      if (wr && paddr == cog_pkg::OFS_STICKY) begin
         next_st.sticky = st.sticky & ~pwdata[11:0];
      end
      next_st.sticky = next_st.sticky | (live_vec ^ st.prev);
      next_st.irq_n  = ~|(next_st.sticky & irq_en);
      next_st.loop_d_n = ~(st.ctrl[cog_pkg::CTRL_PPS]
                           & live.lock_loss[cog_pkg::LOOP_D]);
      next_st.ctrl[cog_pkg::CTRL_HRST] = 1'b0;
      if (wr) begin
         case (paddr)
            cog_pkg::OFS_CTRL:    next_st.ctrl    = pwdata[4:0];
            cog_pkg::OFS_OUT_DIS: next_st.out_dis = pwdata[6:0];
            cog_pkg::OFS_LEVEL:   next_st.level   = pwdata[6:0];
            cog_pkg::OFS_SYNC:    next_st.sync    = pwdata[6:0];
            cog_pkg::OFS_SE:      next_st.se      = pwdata[6:0];
            cog_pkg::OFS_INV:     next_st.inv     = pwdata[6:0];
            cog_pkg::OFS_PWR:     next_st.pwr     = pwdata[9:0];
            cog_pkg::OFS_XP:      next_st.xp      = pwdata[20:0];
            cog_pkg::OFS_DIV_LO:  next_st.div5    = pwdata[15:0];
            cog_pkg::OFS_DIV_HI:  next_st.div6    = pwdata[15:0];
            cog_pkg::OFS_PHASE:   next_st.phase   = pwdata[7:0];
            cog_pkg::OFS_MASK:    next_st.mask    = pwdata[11:0];
            cog_pkg::OFS_DRV:     next_st.drv     = pwdata[13:0];
            default:              next_st.ctrl    = next_st.ctrl;
         endcase
      end
      // drivers
      for (int i = 0; i < cog_pkg::N_OUT; i++) begin
         // sync waits for low phase, async immediate
         if (dis[i]) begin
            if (!st.sync[i] || !src_clk[i] || st.stopped[i]) begin
               next_st.stopped[i] = 1'b1;
            end
         end else begin
            next_st.stopped[i] = 1'b0;
         end
         if (next_st.stopped[i]) begin
            next_st.tru[i] = st.level[i];
            next_st.cmp[i] = st.se[i] ? st.level[i] : ~st.level[i];
         end else begin
            next_st.tru[i] = src_clk[i];
            next_st.cmp[i] = (st.se[i] && !st.inv[i]) ? src_clk[i]
                                                        : ~src_clk[i];
         end
      end
      next_st.prdata = 32'h00000000;
      if (rd) begin
         case (paddr)
            cog_pkg::OFS_CTRL:    next_st.prdata[4:0]  = st.ctrl;
            cog_pkg::OFS_OUT_DIS: next_st.prdata[6:0]  = st.out_dis;
            cog_pkg::OFS_LEVEL:   next_st.prdata[6:0]  = st.level;
            cog_pkg::OFS_SYNC:    next_st.prdata[6:0]  = st.sync;
            cog_pkg::OFS_SE:      next_st.prdata[6:0]  = st.se;
            cog_pkg::OFS_INV:     next_st.prdata[6:0]  = st.inv;
            cog_pkg::OFS_PWR:     next_st.prdata[9:0]  = st.pwr;
            cog_pkg::OFS_XP:      next_st.prdata[20:0] = st.xp;
            cog_pkg::OFS_DIV_LO:  next_st.prdata[15:0] = st.div5;
            cog_pkg::OFS_DIV_HI:  next_st.prdata[15:0] = st.div6;
            cog_pkg::OFS_PHASE:   next_st.prdata[7:0]  = st.phase;
            cog_pkg::OFS_MASK:    next_st.prdata[11:0] = st.mask;
            cog_pkg::OFS_STICKY:  next_st.prdata[11:0] = st.sticky;
            cog_pkg::OFS_LIVE:    next_st.prdata[11:0] = live_vec;
            cog_pkg::OFS_DRV:     next_st.prdata[13:0] = st.drv;
            cog_pkg::OFS_STATE:   next_st.prdata[6:0]  = st.stopped;
            default:              next_st.prdata       = 32'h00000000;
         endcase
      end
   end

   // ----------------------------------------
   // state register
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st          <= '0;
         st.sync     <= 7'h7F;
         st.xp       <= cog_pkg::RST_XP;
         st.div5     <= cog_pkg::RST_DIV;
         st.div6     <= cog_pkg::RST_DIV;
         st.drv      <= cog_pkg::RST_DRV;
         st.stopped  <= 7'h7F;
         st.irq_n    <= 1'b1;
         st.loop_d_n <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   assign clk_out_true           = st.tru;
   assign clk_out_comp           = st.cmp;
   assign single_ended_drive_sel = st.drv;
   assign irq_out_n              = st.irq_n;
   assign loop_d_unlock_pin_n    = st.loop_d_n;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   property p_irq_mask;
      @(posedge pclk) disable iff (!presetn)
      ((st.sticky | (live_vec ^ st.prev)) & irq_en) == 12'h000 |=> irq_out_n;
   endproperty
   a_irq_mask: assert property (p_irq_mask)
      else $error("masked flag raised interrupt");

   property p_irq_set;
      @(posedge pclk) disable iff (!presetn)
      ((live_vec ^ st.prev) & irq_en) != 12'h000 |=> !irq_out_n;
   endproperty
   a_irq_set: assert property (p_irq_set)
      else $error("change missed interrupt");

   property p_sticky_hold;
      @(posedge pclk) disable iff (!presetn)
      st.sticky[0] && !(wr && paddr == cog_pkg::OFS_STICKY) |=> st.sticky[0];
   endproperty
   a_sticky_hold: assert property (p_sticky_hold)
      else $error("sticky dropped without clear");

   property p_pin_off;
      @(posedge pclk) disable iff (!presetn)
      global_out_en_n && st.sync == 7'h00 |=> st.stopped == 7'h7F;
   endproperty
   a_pin_off: assert property (p_pin_off)
      else $error("pin did not disable");

   property p_level;
      @(posedge pclk) disable iff (!presetn)
      st.stopped[0] |-> clk_out_true[0] == $past(st.level[0]);
   endproperty
   a_level: assert property (p_level)
      else $error("static level wrong");

   property p_async;
      @(posedge pclk) disable iff (!presetn)
      dis[1] && !st.sync[1] |=> st.stopped[1];
   endproperty
   a_async: assert property (p_async)
      else $error("async stop late");

   property p_loopd;
      @(posedge pclk) disable iff (!presetn)
      st.ctrl[cog_pkg::CTRL_PPS] && live.lock_loss[cog_pkg::LOOP_D]
      |=> !loop_d_unlock_pin_n;
   endproperty
   a_loopd: assert property (p_loopd)
      else $error("loop d pin not asserted");

   property p_hrst;
      @(posedge pclk) disable iff (!presetn)
      hard_rst |=> cnt5 == 16'h0000 && cnt6 == 16'h0000;
   endproperty
   a_hrst: assert property (p_hrst)
      else $error("dividers not reset");

   property p_irq_hold;
      @(posedge pclk) disable iff (!presetn)
      !irq_out_n && !wr |=> !irq_out_n;
   endproperty
   a_irq_hold: assert property (p_irq_hold)
      else $error("interrupt released without clear");

   property p_xtal;
      @(posedge pclk) disable iff (!presetn)
      !osc_valid && !st.ctrl[cog_pkg::CTRL_XKEEP] && st.sync == 7'h00
      |=> st.stopped == 7'h7F;
   endproperty
   a_xtal: assert property (p_xtal)
      else $error("crystal loss did not disable");

   property p_run;
      @(posedge pclk) disable iff (!presetn)
      !dis[0] |=> !st.stopped[0];
   endproperty
   a_run: assert property (p_run)
      else $error("enabled driver still stopped");

   property p_in_phase;
      @(posedge pclk) disable iff (!presetn)
      !st.stopped[2] && $past(st.se[2] && !st.inv[2])
      |-> clk_out_comp[2] == clk_out_true[2];
   endproperty
   a_in_phase: assert property (p_in_phase)
      else $error("single ended pins not in phase");

endmodule

`default_nettype wire

// ### cog_pkg.sv
package cog_pkg;

   // ----------------------------------------
   // sizes
   // ----------------------------------------
   localparam int N_OUT      = 7;
   localparam int N_LOOP     = 3;
   localparam int N_STAT     = 4;
   localparam int N_IND      = N_LOOP * N_STAT;
   localparam int LOOP_D     = 2;

   // ----------------------------------------
   // apb register offsets (byte addresses)
   // ----------------------------------------
   localparam logic [11:0] OFS_CTRL    = 12'h000;
   localparam logic [11:0] OFS_OUT_DIS = 12'h004;
   localparam logic [11:0] OFS_LEVEL   = 12'h008;
   localparam logic [11:0] OFS_SYNC    = 12'h00C;
   localparam logic [11:0] OFS_SE      = 12'h010;
   localparam logic [11:0] OFS_INV     = 12'h014;
   localparam logic [11:0] OFS_PWR     = 12'h018;
   localparam logic [11:0] OFS_XP      = 12'h01C;
   localparam logic [11:0] OFS_DIV_LO  = 12'h020;
   localparam logic [11:0] OFS_PHASE   = 12'h024;
   localparam logic [11:0] OFS_MASK    = 12'h028;
   localparam logic [11:0] OFS_STICKY  = 12'h02C;
   localparam logic [11:0] OFS_LIVE    = 12'h030;
   localparam logic [11:0] OFS_DRV     = 12'h034;
   localparam logic [11:0] OFS_STATE   = 12'h038;
   localparam logic [11:0] OFS_DIV_HI  = 12'h03C;

   // ----------------------------------------
   // ctrl register fields
   // ----------------------------------------
   localparam int CTRL_PPS     = 0;
   localparam int CTRL_LOLDIS  = 1;
   localparam int CTRL_XKEEP   = 2;
   localparam int CTRL_CASCADE = 3;
   localparam int CTRL_HRST    = 4;

   // ----------------------------------------
   // reset values
   // ----------------------------------------
   localparam logic [6:0]  RST_OUT7   = 7'h00;
   localparam logic [20:0] RST_XP     = 21'h000000;
   localparam logic [15:0] RST_DIV    = 16'h0001;
   localparam logic [7:0]  RST_PHASE  = 8'h00;
   localparam logic [11:0] RST_MASK   = 12'h000;
   localparam logic [13:0] RST_DRV    = 14'h2AAA;
   localparam logic [1:0]  DRV_NONE   = 2'h0;

   // ----------------------------------------
   // carriers
   // ----------------------------------------
   typedef struct packed {
      logic [N_LOOP-1:0] lock_loss;
      logic [N_LOOP-1:0] los;
      logic [N_LOOP-1:0] oof;
      logic [N_LOOP-1:0] hold;
   } cog_stat_t;

   typedef struct packed {
      logic              [4:0]  ctrl;
      logic              [6:0]  out_dis;
      logic              [6:0]  level;
      logic              [6:0]  sync;
      logic              [6:0]  se;
      logic              [6:0]  inv;
      logic              [9:0]  pwr;
      logic              [20:0] xp;
      logic              [15:0] div5;
      logic              [15:0] div6;
      logic              [7:0]  phase;
      logic              [11:0] mask;
      logic              [11:0] sticky;
      logic              [11:0] prev;
      logic              [13:0] drv;
      logic              [6:0]  stopped;
      logic              [6:0]  tru;
      logic              [6:0]  cmp;
      logic              [31:0] prdata;
      logic                     irq_n;
      logic                     loop_d_n;
   } cog_state_t;

endpackage

// ### cog_far_model.sv
`timescale 1ns/10ps
`default_nettype none

module cog_far_model (
   // clock and reset
   input  wire logic            pclk,
   input  wire logic            presetn,
   // downstream receivers
   input  wire logic [6:0]      clk_out_true,
   output logic      [6:0][7:0] edge_cnt,
   // synthesis loop clocks
   output logic      [2:0]      loop_clk
);
   logic [2:0] div;
   logic [6:0] last;

   // ----------------------------------------
   // loops at pclk/2, /4, /8; receivers count edges
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div      <= 3'h0;
         last     <= 7'h00;
         edge_cnt <= 56'h0;
      end else begin
         div  <= div + 3'h1;
         last <= clk_out_true;
         for (int i = 0; i < 7; i++) begin
            edge_cnt[i] <= edge_cnt[i] + {7'h00, last[i] ^ clk_out_true[i]};
         end
      end
   end

   assign loop_clk = div;

endmodule

`default_nettype wire

// ### tb_top.sv
`timescale 1ns/10ps
`default_nettype none

module tb_top;
   logic               pclk;
   logic               presetn;
   logic               psel;
   logic               penable;
   logic               pwrite;
   logic        [11:0] paddr;
   logic        [31:0] pwdata;
   logic        [31:0] prdata;
   logic        [31:0] rd;
   logic               pready;
   logic               pslverr;
   logic        [2:0]  loop_clk;
   cog_pkg::cog_stat_t live;
   logic        [11:0] ind;
   logic               osc_valid;
   logic               oe_n;
   logic        [6:0]  tru;
   logic        [6:0]  cmp;
   logic        [13:0] dsel;
   logic               xalarm;
   logic               irq_n;
   logic               dpin_n;
   logic               div_rst;
   logic   [6:0][7:0]  ecnt;
   logic        [15:0] lfsr;
   logic        [7:0]  c5;
   logic        [7:0]  c6;
   int                 bad_count;
   int                 n_tests;
   int                 idx;
   int                 k;

   assign live = {ind[2:0], ind[5:3], ind[8:6], ind[11:9]};

   cog_clock_output_gating i_cog_clock_output_gating (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
      .prdata(prdata), .pslverr(pslverr), .loop_clk(loop_clk),
      .live(live), .osc_valid(osc_valid), .global_out_en_n(oe_n),
      .clk_out_true(tru), .clk_out_comp(cmp),
      .single_ended_drive_sel(dsel), .crystal_loss_alarm(xalarm),
      .irq_out_n(irq_n), .loop_d_unlock_pin_n(dpin_n),
      .div_reset(div_rst)
   );

   cog_far_model i_cog_far_model (
      .pclk(pclk), .presetn(presetn), .clk_out_true(tru),
      .edge_cnt(ecnt), .loop_clk(loop_clk)
   );

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [15:0] nxt(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   function automatic logic irq_exp(input logic m, input logic pps,
                                    input int i);
      return m | (pps & (i % 3 == 2));
   endfunction

   task automatic results;
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         bad_count++;
         results();
      end
      rd = prdata;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic act(input int i, input logic run);
      logic [7:0] c0;
      repeat (8) @(posedge pclk);
      c0 = ecnt[i];
      repeat (24) @(posedge pclk);
      chk({31'h0, ecnt[i] != c0}, {31'h0, run});
   endtask

   task automatic irq_after(input logic e);
      repeat (3) @(posedge pclk);
      chk({31'h0, irq_n}, {31'h0, e});
   endtask

   task automatic phase_chk(input int p);
      logic [7:0] h;
      h = 8'h00;
      for (int j = 0; j < 24; j++) begin
         @(posedge pclk);
         if (j >= 8) chk({31'h0, tru[0]}, {31'h0, h[p]});
         h = {h[6:0], loop_clk[2]};
      end
   endtask

   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      ind = 12'h000;
      osc_valid = 1'b1;
      oe_n = 1'b0;
      lfsr = 16'h46F6;
      bad_count = 0;
      n_tests = 0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk({30'h0, irq_n, dpin_n}, 32'h3);
      apb(1'b0, cog_pkg::OFS_DRV, 32'h0);
      chk(rd, {18'h0, cog_pkg::RST_DRV});
      apb(1'b1, cog_pkg::OFS_DRV, 32'h0000_2AAB);
      apb(1'b0, cog_pkg::OFS_DRV, 32'h0);
      chk({30'h0, dsel[1:0]}, 32'h3);
      apb(1'b0, 12'h0FC, 32'h0);
      chk(rd, 32'h0);
      for (int i = 0; i < 7; i++) act(i, 1'b1);
      apb(1'b1, cog_pkg::OFS_SE, 32'h7F);
      repeat (4) @(posedge pclk);
      chk({25'h0, cmp}, {25'h0, tru});
      apb(1'b1, cog_pkg::OFS_INV, 32'h7F);
      repeat (4) @(posedge pclk);
      chk({25'h0, cmp}, {25'h0, ~tru});
      // pin, bit, driver power, crystal and lock-loss disables with random level
      for (int s = 0; s < 5; s++) begin
         lfsr = nxt(lfsr);
         apb(1'b1, cog_pkg::OFS_LEVEL, {25'h0, {7{lfsr[0]}}});
         apb(1'b1, cog_pkg::OFS_SYNC, {25'h0, {7{s % 3 != 0}}});
         case (s)
            0: oe_n <= 1'b1;
            1: apb(1'b1, cog_pkg::OFS_OUT_DIS, 32'h1);
            2: apb(1'b1, cog_pkg::OFS_PWR, 32'h1);
            3: osc_valid <= 1'b0;
            default: begin
               apb(1'b1, cog_pkg::OFS_CTRL, 32'h2);
               ind <= 12'h001;
            end
         endcase
         act(0, 1'b0);
         chk({31'h0, tru[0]}, {31'h0, lfsr[0]});
         if (s == 3) chk({31'h0, xalarm}, 32'h1);
         oe_n <= 1'b0;
         osc_valid <= 1'b1;
         apb(1'b1, cog_pkg::OFS_OUT_DIS, 32'h0);
         apb(1'b1, cog_pkg::OFS_PWR, 32'h0);
         apb(1'b1, cog_pkg::OFS_CTRL, 32'h0);
         act(0, 1'b1);
      end
      act(0, 1'b1);
      osc_valid <= 1'b0;
      apb(1'b1, cog_pkg::OFS_CTRL, 32'h4);
      act(0, 1'b1);
      osc_valid <= 1'b1;
      // no loop selected on driver 0
      apb(1'b1, cog_pkg::OFS_XP, 32'h3);
      act(0, 1'b0);
      apb(1'b1, cog_pkg::OFS_XP, 32'h0);
      ind <= 12'h000;
      apb(1'b1, cog_pkg::OFS_STICKY, 32'hFFF);
      // random indicator changes under random masks
      repeat (12) begin
         lfsr = nxt(lfsr);
         idx = int'(lfsr[7:4]) % 12;
         apb(1'b1, cog_pkg::OFS_MASK, {31'h0, lfsr[0]} << idx);
         ind[idx] <= ~ind[idx];
         irq_after(irq_exp(lfsr[0], 1'b0, idx));
         apb(1'b0, cog_pkg::OFS_LIVE, 32'h0);
         chk(rd, {20'h0, ind});
         if (!lfsr[0]) begin
            apb(1'b0, cog_pkg::OFS_STICKY, 32'h0);
            chk({31'h0, rd[idx]}, 32'h1);
         end
         apb(1'b1, cog_pkg::OFS_STICKY, 32'hFFF);
         irq_after(1'b1);
      end
      // pps mode: loop D off the interrupt, lock loss on pin
      apb(1'b1, cog_pkg::OFS_MASK, 32'h0);
      apb(1'b1, cog_pkg::OFS_CTRL, 32'h1);
      ind <= ind ^ 12'h004;
      irq_after(irq_exp(1'b0, 1'b1, 2));
      chk({31'h0, dpin_n}, {31'h0, ~ind[2]});
      ind <= ind ^ 12'h008;
      irq_after(irq_exp(1'b0, 1'b1, 3));
      apb(1'b1, cog_pkg::OFS_STICKY, 32'hFFF);
      // loop D taps in pps mode, fixed then random
      apb(1'b1, cog_pkg::OFS_XP, 32'h2);
      apb(1'b1, cog_pkg::OFS_PHASE, 32'h4);
      phase_chk(4);
      lfsr = nxt(lfsr);
      apb(1'b1, cog_pkg::OFS_PHASE, {29'h0, lfsr[2:0]});
      phase_chk(int'(lfsr[2:0]));
      apb(1'b1, cog_pkg::OFS_XP, 32'h0);
      // cascade makes output 5 slower than output 6
      apb(1'b1, cog_pkg::OFS_DIV_LO, 32'h4);
      apb(1'b1, cog_pkg::OFS_DIV_HI, 32'h2);
      apb(1'b1, cog_pkg::OFS_CTRL, 32'h8);
      repeat (8) @(posedge pclk);
      c5 = ecnt[5];
      c6 = ecnt[6];
      repeat (64) @(posedge pclk);
      chk({31'h0, ecnt[5] - c5 < ecnt[6] - c6}, 32'h1);
      apb(1'b1, cog_pkg::OFS_CTRL, 32'h10);
      k = 0;
      while (div_rst !== 1'b1 && k < 8) begin
         @(posedge pclk);
         k++;
      end
      chk({31'h0, div_rst}, 32'h1);
      results();
   end

endmodule

`default_nettype wire
